// *** ccs_clock_switch.sv ***
// cpu and main clock source selection with delayed switchover
// How it works
// RQ1: software starts internal oscillator and selects it as main before leaving subsystem clock.
// RQ2: software readies the crystal, waits stabilization and sees main status one first.
// RQ3: writing amplifier gain to one withholds cpu clock for at least 5 us.
// RQ4: software enables external main input and sees main status one before switching.
// RQ5: software enables external subsystem input before moving cpu onto it.
// RQ6: cpu source and divider selections take effect only after counted cycles of the old clock, or of the subsystem clock when moving to it.
// RQ7: cpu source status bit reports whether cpu runs from main or subsystem clock.
// RQ8: divider change waits 16 down to 1 old cpu clocks; leaving subsystem waits 2.
// RQ9: moving to subsystem waits two subsystem periods, counted in whole clocks.
// RQ10: software never changes divider together with a main-to-subsystem switch.
// RQ11: main source selection takes effect after one old and two new main source clocks.
// RQ12: main source status bit reports internal or high-speed main clock.
// RQ13: main switch takes one old clock plus two new-source clocks.
// RQ14: high-speed path enable must precede switching; it changes once after reset.
// RQ15: internal oscillator stopped only while cpu runs from another clock.
// RQ16: main oscillator stopped only while cpu runs from another clock.
// RQ17: subsystem oscillator stopped only while cpu runs from main clock.
// RQ18: software readies crystal before moving cpu from internal oscillator to it.
// RQ19: amplifier gain changes once after reset; later writes leave it unchanged.
// RQ20: switches land on source tick boundaries; status follows the actual source.
`timescale 1ns/1ps
`include "ccs_map.svh"

module ccs_clock_switch
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       int_hs_osc,
	input  wire logic       hs_sys_osc,
	input  wire logic       sub_osc,
	output logic            cpu_clk_en,
	output logic            main_clk_en,
	output logic            int_osc_run,
	output logic            main_osc_run,
	output logic            sub_osc_run
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	ccs_pkg::ccs_div_t main_div_sel;
	ccs_pkg::ccs_div_t div_eff;
	ccs_pkg::ccs_div_t tgt_div;
	ccs_pkg::ccs_msw_t msw_state;
	logic              cpu_src_select;
	logic              cpu_src_status;
	logic              tgt_css;
	logic              sub_xtal_start_ctl;
	logic              main_src_select;
	logic              main_src_status;
	logic              hs_path_enable;
	logic              hs_path_done;
	logic              hs_amp_gain;
	logic              amp_done;
	logic              sub_ext_clk_sel;
	logic              sub_osc_select;
	logic              main_ext_clk_sel;
	logic              main_osc_select;
	logic              main_osc_stop;
	logic              hs_int_osc_stop;
	logic        [2:0] sync1;
	logic        [2:0] sync2;
	logic        [2:0] sync3;
	logic        [3:0] div_cnt;
	logic        [4:0] cpu_cnt;
	logic              cpu_busy;
	logic        [1:0] new_cnt;
	logic        [9:0] hold_cnt;
	logic              int_tick;
	logic              hs_tick;
	logic              sub_tick;
	logic              main_tick;
	logic              old_tick;
	logic              new_tick;
	logic              cpu_tick;
	logic              cnt_tick;
	logic        [3:0] div_mask;
	logic              wr_pcc;
	logic              wr_mcm;
	logic              wr_osc;
	logic              amp_set;

	assign wr_pcc = wr && addr == `CCS_OFS_PROC_CLK;
	assign wr_mcm = wr && addr == `CCS_OFS_MAIN_MODE;
	assign wr_osc = wr && addr == `CCS_OFS_OSC_CTL;
	// first gain write to one starts the cpu hold in the same cycle
	assign amp_set = wr_osc && !amp_done && wdata[`CCS_AMP_BIT] && !hs_amp_gain;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			main_div_sel       <= `CCS_RST_DIV;
			cpu_src_select     <= 1'b0;
			sub_xtal_start_ctl <= 1'b0;
			main_src_select    <= 1'b0;
			sub_ext_clk_sel    <= 1'b0;
			sub_osc_select     <= 1'b0;
			main_ext_clk_sel   <= 1'b0;
			main_osc_select    <= 1'b0;
			main_osc_stop      <= `CCS_RST_MAIN_OSC_STOP;
			hs_int_osc_stop    <= `CCS_RST_HS_INT_OSC_STOP;
		end
		else
		begin
			if (wr_pcc)
			begin
				main_div_sel       <= (wdata[`CCS_DIV_MSB:`CCS_DIV_LSB] > `CCS_DIV_MAX) ?
				                      `CCS_DIV_MAX : wdata[`CCS_DIV_MSB:`CCS_DIV_LSB];
				cpu_src_select     <= wdata[`CCS_CSS_BIT];
				sub_xtal_start_ctl <= wdata[`CCS_XTS_BIT];
			end
			if (wr_mcm)
				main_src_select <= wdata[`CCS_MSEL_BIT];
			if (wr_osc)
			begin
				sub_ext_clk_sel  <= wdata[`CCS_SXCLK_BIT];
				sub_osc_select   <= wdata[`CCS_SOSC_BIT];
				main_ext_clk_sel <= wdata[`CCS_MXCLK_BIT];
				main_osc_select  <= wdata[`CCS_MOSC_BIT];
				main_osc_stop    <= wdata[`CCS_MAIN_OSC_STOP_BIT];
				hs_int_osc_stop  <= wdata[`CCS_HS_INT_OSC_STOP_BIT];
			end
		end
	end

	// ----------------------------------------
	// write-once bits
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			hs_path_enable <= 1'b0;
			hs_path_done   <= 1'b0;
			hs_amp_gain    <= 1'b0;
			amp_done       <= 1'b0;
		end
		else
		begin
			if (wr_mcm && !hs_path_done && wdata[`CCS_HSEN_BIT] != hs_path_enable)
			begin
				hs_path_enable <= wdata[`CCS_HSEN_BIT]; // RQ14
				hs_path_done   <= 1'b1; // RQ14
			end
			if (wr_osc && !amp_done && wdata[`CCS_AMP_BIT] != hs_amp_gain)
			begin
				hs_amp_gain <= wdata[`CCS_AMP_BIT]; // RQ19
				amp_done    <= 1'b1; // RQ19
			end
		end
	end

	// ----------------------------------------
	// oscillator tick recovery
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
		end
		else
		begin
			sync1 <= {sub_osc, hs_sys_osc, int_hs_osc};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	assign int_tick  = sync2[0] && !sync3[0] && !hs_int_osc_stop;
	assign hs_tick   = sync2[1] && !sync3[1] && !main_osc_stop && main_osc_select;
	assign sub_tick  = sync2[2] && !sync3[2] && sub_osc_select;
	assign main_tick = main_src_status ? hs_tick : int_tick;
	assign old_tick  = main_tick;
	assign new_tick  = main_src_status ? int_tick : hs_tick;

	// ----------------------------------------
	// main source switch
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			msw_state       <= ccs_pkg::MSW_IDLE;
			main_src_status <= 1'b0;
			new_cnt         <= 2'h0;
		end
		else
		begin
			unique case (msw_state)
				ccs_pkg::MSW_IDLE:
					if (main_src_select != main_src_status && (main_src_status || hs_path_enable)) // RQ14
						msw_state <= ccs_pkg::MSW_OLD; // RQ11
				ccs_pkg::MSW_OLD:
					if (old_tick)
					begin
						msw_state <= ccs_pkg::MSW_NEW; // RQ13
						new_cnt   <= 2'h0;
					end
				ccs_pkg::MSW_NEW:
					if (new_tick)
					begin
						if (new_cnt == 2'h1)
						begin
							main_src_status <= !main_src_status; // RQ12 RQ20
							msw_state       <= ccs_pkg::MSW_IDLE;
						end
						new_cnt <= new_cnt + 2'h1; // RQ13
					end
			endcase
		end
	end

	// ----------------------------------------
	// cpu divider and source switch
	// ----------------------------------------
	assign div_mask = 4'((5'h1 << div_eff) - 5'h1);
	assign cpu_tick = cpu_src_status ? sub_tick : (main_tick && (div_cnt & div_mask) == div_mask);
	assign cnt_tick = (tgt_css != cpu_src_status) ? sub_tick : cpu_tick;

	always_ff @(posedge mclk)
	begin
		if (rst)
			div_cnt <= 4'h0;
		else if (main_tick)
			div_cnt <= div_cnt + 4'h1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cpu_busy       <= 1'b0;
			cpu_cnt        <= 5'h0;
			tgt_css        <= 1'b0;
			tgt_div        <= `CCS_RST_DIV;
			div_eff        <= `CCS_RST_DIV;
			cpu_src_status <= 1'b0;
		end
		else if (!cpu_busy)
		begin
			if (cpu_src_select != cpu_src_status || main_div_sel != div_eff)
			begin
				cpu_busy <= 1'b1; // RQ6
				tgt_css  <= cpu_src_select;
				tgt_div  <= main_div_sel;
				cpu_cnt  <= (cpu_src_select != cpu_src_status) ? `CCS_SUB_TICKS : // RQ8 RQ9
				            (`CCS_DIV_TOP >> div_eff); // RQ8
			end
		end
		else if (cnt_tick)
		begin
			if (cpu_cnt == 5'h1)
			begin
				cpu_busy       <= 1'b0;
				cpu_src_status <= tgt_css; // RQ7 RQ20
				div_eff        <= tgt_div; // RQ6
			end
			cpu_cnt <= cpu_cnt - 5'h1;
		end
	end

	// ----------------------------------------
	// clock hold after gain change
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
			hold_cnt <= 10'h0;
		else if (amp_set)
			hold_cnt <= 10'(`CCS_HOLD_CYC); // RQ3
		else if (hold_cnt != 10'h0)
			hold_cnt <= hold_cnt - 10'h1;
	end

	// ----------------------------------------
	// outputs and read port
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cpu_clk_en   <= 1'b0;
			main_clk_en  <= 1'b0;
			int_osc_run  <= 1'b0;
			main_osc_run <= 1'b0;
			sub_osc_run  <= 1'b0;
		end
		else
		begin
			cpu_clk_en   <= cpu_tick && hold_cnt == 10'h0 && !amp_set; // RQ3
			main_clk_en  <= main_tick;
			int_osc_run  <= !hs_int_osc_stop;
			main_osc_run <= !main_osc_stop && main_osc_select;
			sub_osc_run  <= sub_osc_select;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			rdata <= 8'h0;
		else if (rd)
		begin
			rdata <= 8'h0;
			unique case (addr)
				`CCS_OFS_PROC_CLK:  rdata <= {1'b0, sub_xtal_start_ctl, cpu_src_status, cpu_src_select, 1'b0,
				                              main_div_sel}; // RQ7
				`CCS_OFS_MAIN_MODE: rdata <= {5'h0, hs_path_enable, main_src_status, main_src_select}; // RQ12
				`CCS_OFS_OSC_CTL:   rdata <= {main_osc_select, main_ext_clk_sel, sub_osc_select, sub_ext_clk_sel,
				                              1'b0, hs_int_osc_stop, main_osc_stop, hs_amp_gain};
				default:            rdata <= 8'h0;
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_amp_set;
		wr_osc && !amp_done && wdata[`CCS_AMP_BIT] && !hs_amp_gain;
	endsequence

	sequence s_cpu_quiet;
		(!cpu_clk_en)[*8];
	endsequence

	property p_hold;
		@(posedge mclk) disable iff (rst) s_amp_set |-> ##1 s_cpu_quiet;
	endproperty
	a_hold: assert property (p_hold) else $error("cpu clock not withheld after gain set"); // RQ3

	property p_hold_len;
		@(posedge mclk) disable iff (rst) s_amp_set |-> ##1 hold_cnt == 10'(`CCS_HOLD_CYC);
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold length wrong"); // RQ3

	property p_cls_when;
		@(posedge mclk) disable iff (rst) $changed(cpu_src_status) |-> $past(cpu_cnt) == 5'h1 && $past(sub_tick);
	endproperty
	a_cls_when: assert property (p_cls_when) else $error("cpu source changed off a subsystem tick"); // RQ9

	property p_div_when;
		@(posedge mclk) disable iff (rst) $changed(div_eff) |-> $past(cpu_busy) && $past(cpu_cnt) == 5'h1;
	endproperty
	a_div_when: assert property (p_div_when) else $error("divider changed without wait"); // RQ8

	property p_div_wait;
		@(posedge mclk) disable iff (rst)
			!cpu_busy && main_div_sel != div_eff && cpu_src_select == cpu_src_status
			|-> ##1 cpu_busy && cpu_cnt == (`CCS_DIV_TOP >> $past(div_eff));
	endproperty
	a_div_wait: assert property (p_div_wait) else $error("divider wait count wrong"); // RQ8

	property p_mcs_when;
		@(posedge mclk) disable iff (rst)
			$changed(main_src_status) |-> $past(msw_state) == ccs_pkg::MSW_NEW && $past(new_tick);
	endproperty
	a_mcs_when: assert property (p_mcs_when) else $error("main source changed off new tick"); // RQ13

	property p_mcs_path;
		@(posedge mclk) disable iff (rst) $rose(main_src_status) |-> hs_path_enable;
	endproperty
	a_mcs_path: assert property (p_mcs_path) else $error("high-speed switch without path enable"); // RQ14

	property p_once;
		@(posedge mclk) disable iff (rst) $past(hs_path_done) && $past(amp_done) |-> $stable(hs_path_enable)
			&& $stable(hs_amp_gain);
	endproperty
	a_once: assert property (p_once) else $error("write-once bit changed twice"); // RQ19

	property p_rd_status;
		@(posedge mclk) disable iff (rst) rd && addr == `CCS_OFS_PROC_CLK |-> ##1 rdata[`CCS_CLS_BIT] ==
			$past(cpu_src_status);
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("cpu source status misread"); // RQ7

endmodule : ccs_clock_switch

// *** ccs_clock_switch_tb_top.sv ***
// self-checking testbench of the clock switchover block
`timescale 1ns/1ps

module ccs_clock_switch_tb_top;
	typedef struct {logic [1:0] a; logic [7:0] w; logic [7:0] e;} ccs_row_t;

	logic       mclk;
	logic       rst;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       int_hs_osc;
	logic       hs_sys_osc;
	logic       sub_osc;
	logic       cpu_clk_en;
	logic       main_clk_en;
	logic       int_osc_run;
	logic       main_osc_run;
	logic       sub_osc_run;
	logic [7:0] d;
	logic [4:0] cnt;
	logic [2:0] hcnt;
	int         fails;
	int         comparisons;
	int         n;
	ccs_row_t   rows [5];

	ccs_clock_switch ccs_clock_switch_i (
		.mclk         (mclk),
		.rst          (rst),
		.addr         (addr),
		.wdata        (wdata),
		.wr           (wr),
		.rd           (rd),
		.rdata        (rdata),
		.int_hs_osc   (int_hs_osc),
		.hs_sys_osc   (hs_sys_osc),
		.sub_osc      (sub_osc),
		.cpu_clk_en   (cpu_clk_en),
		.main_clk_en  (main_clk_en),
		.int_osc_run  (int_osc_run),
		.main_osc_run (main_osc_run),
		.sub_osc_run  (sub_osc_run)
	);

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ----------------------------------------
	// oscillators: internal 4, high-speed 6, subsystem 16 cycles
	// ----------------------------------------
	always @(posedge mclk)
	begin
		cnt <= cnt + 5'h1;
		hcnt <= (hcnt == 3'h5) ? 3'h0 : hcnt + 3'h1;
		int_hs_osc <= cnt[1];
		sub_osc <= cnt[3];
		hs_sys_osc <= (hcnt < 3'h3);
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task print_verdict();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
			fails++;
		end
	endtask : chk

	task wr_reg(input logic [1:0] a, input logic [7:0] w);
		@(posedge mclk);
		addr <= a;
		wdata <= w;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [1:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task wait_bit(input logic [1:0] a, input int b, input logic v);
		int t;
		t = 0;
		rd_reg(a);
		while (d[b] !== v && t < 300)
		begin
			rd_reg(a);
			t++;
		end
		if (d[b] !== v)
		begin
			fails++;
			print_verdict();
		end
	endtask : wait_bit

	// cycles between two enable pulses; sel 1 watches the main clock
	task gap(input logic sel, output int g);
		int t;
		#1;
		t = 0;
		g = 0;
		while ((sel ? main_clk_en : cpu_clk_en) !== 1'b1 && t < 4000)
		begin
			@(posedge mclk);
			#1;
			t++;
		end
		do
		begin
			@(posedge mclk);
			#1;
			g++;
		end while ((sel ? main_clk_en : cpu_clk_en) !== 1'b1 && g < 4000);
		if (t >= 4000 || g >= 4000)
		begin
			fails++;
			print_verdict();
		end
	endtask : gap

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		cnt = 5'h00;
		hcnt = 3'h0;
		int_hs_osc = 1'b0;
		hs_sys_osc = 1'b0;
		sub_osc = 1'b0;
		fails = 0;
		comparisons = 0;
		rows = '{'{2'h0, 8'h03, 8'h03}, '{2'h0, 8'h07, 8'h04}, '{2'h3, 8'hff, 8'h00},
			'{2'h0, 8'h40, 8'h40}, '{2'h0, 8'h00, 8'h00}};
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		chk("int_osc_run", 1, int_osc_run);
		chk("main_osc_run", 0, main_osc_run);
		rd_reg(2'h0);
		chk("proc_clk_ctrl_reg", 8'h00, d);
		rd_reg(2'h1);
		chk("main_clk_mode_reg", 8'h00, d);
		rd_reg(2'h2);
		chk("osc_ctl", 8'h02, d);
		foreach (rows[i])
		begin
			wr_reg(rows[i].a, rows[i].w);
			rd_reg(rows[i].a);
			chk("row_readback", rows[i].e, d);
		end
		for (int k = 0; k < 5; k++)
		begin
			wr_reg(2'h0, k[7:0]);
			repeat (200) @(posedge mclk);
			gap(1'b0, n);
			chk("cpu_gap_div", 4 << k, n);
		end
		wr_reg(2'h2, 8'h32);
		@(posedge mclk);
		#1;
		chk("sub_osc_run_on", 1, sub_osc_run);
		wr_reg(2'h0, 8'h14);
		rd_reg(2'h0);
		chk("cls_before", 0, d[5]);
		wait_bit(2'h0, 5, 1'b1);
		chk("cls_sub", 1, d[5]);
		gap(1'b0, n);
		chk("cpu_gap_sub", 16, n);
		wr_reg(2'h0, 8'h02);
		wait_bit(2'h0, 5, 1'b0);
		chk("cls_main", 0, d[5]);
		wr_reg(2'h2, 8'h02);
		@(posedge mclk);
		#1;
		chk("sub_osc_run_off", 0, sub_osc_run);
		chk("main_osc_run_off", 0, main_osc_run);
		repeat (200) @(posedge mclk);
		gap(1'b0, n);
		chk("cpu_gap_back", 16, n);
		wr_reg(2'h1, 8'h01);
		repeat (100) @(posedge mclk);
		rd_reg(2'h1);
		chk("mcs_no_path", 0, d[1]);
		wr_reg(2'h2, 8'hb0);
		repeat (100) @(posedge mclk);
		wr_reg(2'h1, 8'h05);
		wait_bit(2'h1, 1, 1'b1);
		chk("mcs_hs", 1, d[1]);
		chk("main_osc_run_on", 1, main_osc_run);
		gap(1'b1, n);
		chk("main_gap_hs", 6, n);
		wr_reg(2'h0, 8'h12);
		wait_bit(2'h0, 5, 1'b1);
		chk("cls_sub_xtal", 1, d[5]);
		wr_reg(2'h0, 8'h02);
		wait_bit(2'h0, 5, 1'b0);
		chk("cls_xtal", 0, d[5]);
		wr_reg(2'h0, 8'h12);
		wait_bit(2'h0, 5, 1'b1);
		chk("cls_sub_ext", 1, d[5]);
		wr_reg(2'h2, 8'hf0);
		wr_reg(2'h0, 8'h02);
		wait_bit(2'h0, 5, 1'b0);
		chk("cls_ext", 0, d[5]);
		wr_reg(2'h1, 8'h01);
		rd_reg(2'h1);
		chk("hs_path_enable_once", 1, d[2]);
		wr_reg(2'h2, 8'hf1);
		#1;
		n = 0;
		while (cpu_clk_en !== 1'b1 && n < 3000)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("cpu_hold", 1, n >= 1000 && n < 3000);
		wr_reg(2'h2, 8'hf0);
		rd_reg(2'h2);
		chk("hs_amp_gain_once", 8'hf1, d);
		wr_reg(2'h2, 8'hf5);
		repeat (3) @(posedge mclk);
		#1;
		chk("int_osc_run_off", 0, int_osc_run);
		print_verdict();
	end
endmodule : ccs_clock_switch_tb_top

// *** ccs_map.svh ***
// register offsets, field positions, reset values and timing counts of the clock switchover block
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCS_OFS_PROC_CLK 2'h0
`define CCS_OFS_MAIN_MODE 2'h1
`define CCS_OFS_OSC_CTL 2'h2

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCS_DIV_LSB 0
`define CCS_DIV_MSB 2
`define CCS_CSS_BIT 4
`define CCS_CLS_BIT 5
`define CCS_XTS_BIT 6
`define CCS_MSEL_BIT 0
`define CCS_MSTS_BIT 1
`define CCS_HSEN_BIT 2
`define CCS_AMP_BIT 0
`define CCS_SXCLK_BIT 4
`define CCS_SOSC_BIT 5
`define CCS_MXCLK_BIT 6
`define CCS_MOSC_BIT 7
`define CCS_MAIN_OSC_STOP_BIT 1
`define CCS_HS_INT_OSC_STOP_BIT 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCS_RST_DIV 3'h0
`define CCS_RST_MAIN_OSC_STOP 1'b1
`define CCS_RST_HS_INT_OSC_STOP 1'b0

// ----------------------------------------
// timing
// ----------------------------------------
`define CCS_CLK_PS 5000
`define CCS_HOLD_NS 5000
`define CCS_HOLD_CYC ((`CCS_HOLD_NS * 1000 + `CCS_CLK_PS - 1) / `CCS_CLK_PS)
`define CCS_SUB_TICKS 5'h2
`define CCS_DIV_TOP 5'h10
`define CCS_DIV_MAX 3'h4

`endif

// *** ccs_pkg.sv ***
// types of the clock switchover block
package ccs_pkg;
	typedef enum logic [1:0] {MSW_IDLE, MSW_OLD, MSW_NEW} ccs_msw_t;
	typedef logic [2:0] ccs_div_t;
endpackage : ccs_pkg
